//--- verilog/fsid_pkg.sv
// Shared constants for the suspend gate and identity readout block
package fsid_pkg;
    // System clock rate
    localparam int CLK_MHZ = 200;
    // Suspend latencies in ns (plain defaults, overridable at the top)
    localparam int PROG_SUSP_LAT_NS = 20000;
    localparam int ERASE_SUSP_LAT_NS = 20000;
    localparam int LAT_W = 24;

    // Opcodes decoded individually by the state machine, status bits and identity shifter
    localparam logic [7:0] OP_IDENTITY_READ = 8'h9F;
    localparam logic [7:0] OP_SUSPEND       = 8'h75;
    localparam logic [7:0] OP_RESUME        = 8'h7A;
    localparam logic [7:0] OP_LATCH_SET     = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;

    // Accepted at any moment after suspend, both suspend types
    localparam logic [7:0] OPS_NOW_BOTH [6] = '{
        8'h05, 8'h15, 8'h66, 8'h99, 8'h00, 8'h48};
    // Accepted at any moment, erase suspend only
    localparam logic [7:0] OPS_NOW_ERASE [2] = '{8'h35, 8'hAB};
    // Accepted after the latency, both suspend types
    localparam logic [7:0] OPS_BOTH [24] = '{
        8'h03, 8'h0B, 8'h0D, 8'h3B, 8'h6B, 8'hBB, 8'hBD, 8'hEB,
        8'hE7, 8'hED, 8'h0C, 8'h0E, 8'h38, 8'hFF, 8'h5A, 8'h9F,
        8'h90, 8'h92, 8'h94, 8'h77, 8'hC0, 8'h7A, 8'h3D, 8'h04};
    // Accepted after the latency, erase suspend only
    localparam logic [7:0] OPS_ERASE [6] = '{
        8'h06, 8'h02, 8'h32, 8'h42, 8'h39, 8'h98};
    // Refused in either suspend type
    localparam logic [7:0] OPS_NEVER [3] = '{8'h44, 8'h36, 8'h7E};

    // Identity readout geometry
    localparam int ID_BITS = 24;
    localparam int ID_CNT_W = 5;
    localparam int OP_BITS = 8;
    localparam int ADDR_W = 24;

    // Region masks: page 256 B, sector 4 KB, blocks 32 KB and 64 KB
    localparam logic [ADDR_W-1:0] MASK_PAGE  = 24'hFFFF00;
    localparam logic [ADDR_W-1:0] MASK_4K    = 24'hFFF000;
    localparam logic [ADDR_W-1:0] MASK_32K   = 24'hFF8000;
    localparam logic [ADDR_W-1:0] MASK_64K   = 24'hFF0000;

    typedef enum logic [1:0] {
        KIND_PAGE, KIND_SECTOR, KIND_BLOCK32, KIND_BLOCK64
    } fsid_kind_e;

    typedef enum logic [2:0] {
        CL_NOW_BOTH, CL_NOW_ERASE, CL_BOTH, CL_ERASE, CL_NEVER, CL_OTHER
    } fsid_class_e;

    typedef enum logic [1:0] {
        ST_IDLE, ST_RUN, ST_SUSP_WAIT, ST_SUSPENDED
    } fsid_state_e;
endpackage

//--- verilog/fsid_top.sv
// Identity readout and program/erase suspend gate of the flash front end
// Operation
// RQ1 - Identity opcode shifts out one maker byte then two device bytes.
// RQ2 - Host may raise chip select anytime during identity output.
// RQ3 - Identity opcode not decoded while program or erase runs.
// RQ4 - Chip select high ends identity command, back to standby.
// RQ5 - Suspend may interrupt page program, sector or block erase.
// RQ6 - While suspended, reads blocked only in the affected page/sector/block.
// RQ7 - After suspend wait latency, then clear latch, set suspend flag.
// RQ8 - Suspend flag set on suspend, cleared on resume.
// RQ9 - Read, ID, wrap, parameter, quad enable accepted in both suspends.
// RQ10 - Latch set, page writes, secreg write, unlocks only in erase suspend.
// RQ11 - Secreg erase and block locks refused in any suspend.
// RQ12 - Resume, latch clear, secreg read, lock status in both suspends.
// RQ13 - Status read, secreg read, reset arm/execute need no latency.
// RQ14 - Resume sets latch and busy bits, clears suspend, continues.
// RQ15 - Host waits resume gap before another suspend.
// RQ16 - Program inside erase suspend not suspendable, blocks resume.
// RQ17 - Opcodes outside accepted set during suspend ignored silently.
`timescale 1ns/1ps
`default_nettype none
module fsid_top #(
    parameter int              PROG_LAT_NS  = fsid_pkg::PROG_SUSP_LAT_NS,
    parameter int              ERASE_LAT_NS = fsid_pkg::ERASE_SUSP_LAT_NS,
    parameter logic [7:0]      MAKER_CODE   = 8'hA5,   // Arbitrary value
    parameter logic [15:0]     DEVICE_CODE  = 16'h5A3C // Arbitrary value
) (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_sclk,
    input  wire logic                        i_cs_n,
    input  wire logic                        i_si,
    output logic                             o_so,
    output logic                             o_so_oe_n,
    input  wire logic                        i_op_start,
    input  wire fsid_pkg::fsid_kind_e        i_op_kind,
    input  wire logic [fsid_pkg::ADDR_W-1:0] i_op_addr,
    input  wire logic                        i_op_done,
    input  wire logic [fsid_pkg::ADDR_W-1:0] i_rd_addr,
    output logic                             o_rd_allowed,
    output logic                             o_cmd_accept,
    output logic                             o_cmd_ignore,
    output logic [7:0]                       o_cmd_code,
    output logic                             o_op_pause,
    output logic                             o_suspend_flag,
    output logic                             o_write_latch_bit,
    output logic                             o_write_in_progress_bit
);
    import fsid_pkg::*;

    localparam logic [LAT_W-1:0] PROG_LAT_CYC =
        LAT_W'((PROG_LAT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [LAT_W-1:0] ERASE_LAT_CYC =
        LAT_W'((ERASE_LAT_NS * CLK_MHZ + 999) / 1000);

    // Opcode class lookup against the acceptance tables
    function automatic fsid_class_e classify(input logic [7:0] op);
        fsid_class_e c;
        c = CL_OTHER;
        foreach (OPS_NEVER[k])     if (OPS_NEVER[k] == op)     c = CL_NEVER;
        foreach (OPS_ERASE[k])     if (OPS_ERASE[k] == op)     c = CL_ERASE;
        foreach (OPS_BOTH[k])      if (OPS_BOTH[k] == op)      c = CL_BOTH;
        foreach (OPS_NOW_ERASE[k]) if (OPS_NOW_ERASE[k] == op) c = CL_NOW_ERASE;
        foreach (OPS_NOW_BOTH[k])  if (OPS_NOW_BOTH[k] == op)  c = CL_NOW_BOTH;
        return c;
    endfunction

    // Address mask of the region touched by an operation kind
    function automatic logic [ADDR_W-1:0] region_mask(input fsid_kind_e k);
        logic [ADDR_W-1:0] m;
        m = MASK_64K;
        case (k)
            KIND_PAGE:    m = MASK_PAGE;
            KIND_SECTOR:  m = MASK_4K;
            KIND_BLOCK32: m = MASK_32K;
            default:      m = MASK_64K;
        endcase
        return m;
    endfunction

    // Pin synchronisers; stage one feeds only stage two
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] si_sync;
    logic       sclk_prev;
    logic       cs_prev;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_sync <= 2'h0;
            cs_sync   <= 2'h3;
            si_sync   <= 2'h0;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], i_sclk};
            cs_sync   <= {cs_sync[0], i_cs_n};
            si_sync   <= {si_sync[0], i_si};
            sclk_prev <= sclk_sync[1];
            cs_prev   <= cs_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_low;
    logic cs_rise;
    assign sclk_rise = sclk_sync[1] & ~sclk_prev;
    assign sclk_fall = ~sclk_sync[1] & sclk_prev;
    assign cs_low    = ~cs_sync[1];
    assign cs_rise   = cs_sync[1] & ~cs_prev;

    // Opcode shifter; only the first byte of a frame is decoded
    logic [7:0] op_shift;
    logic [3:0] op_cnt;
    logic       op_valid;
    logic [7:0] next_op;
    assign next_op = {op_shift[6:0], si_sync[1]};
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            op_shift <= 8'h00;
            op_cnt   <= 4'h0;
            op_valid <= 1'b0;
        end else begin
            op_valid <= 1'b0;
            if (!cs_low) begin
                op_cnt <= 4'h0;
            end else if (sclk_rise && op_cnt < 4'(OP_BITS)) begin
                op_shift <= next_op;
                op_cnt   <= op_cnt + 4'h1;
                op_valid <= (op_cnt == 4'(OP_BITS - 1));
            end
        end
    end

    // Suspend gate state
    fsid_state_e      state;
    fsid_kind_e       kind;
    logic [ADDR_W-1:0] op_addr;
    logic             nested_prog;
    logic [LAT_W-1:0] lat_cnt;
    logic             is_erase;
    fsid_class_e      cls;
    logic             accept;
    assign is_erase = (kind != KIND_PAGE);
    assign cls      = classify(op_shift);

    // Acceptance decision per state and suspend type
    always_comb begin
        accept = 1'b0;
        case (state)
            ST_IDLE: begin
                accept = (op_shift != OP_SUSPEND) && (op_shift != OP_RESUME);
            end
            ST_RUN: begin
                // RQ3 identity undecoded while busy
                // RQ5 suspend interrupts running op
                accept = (op_shift == OP_SUSPEND) || (cls == CL_NOW_BOTH) ||
                         (cls == CL_NOW_ERASE && is_erase);
            end
            ST_SUSP_WAIT: begin
                // RQ13 no latency for these
                accept = (cls == CL_NOW_BOTH) ||
                         (cls == CL_NOW_ERASE && is_erase);
            end
            default: begin
                if (nested_prog) begin
                    // RQ16 busy program blocks resume
                    accept = (cls == CL_NOW_BOTH);
                end else begin
                    // RQ9 RQ10 RQ11 RQ12 RQ17 suspend acceptance table
                    accept = (cls == CL_NOW_BOTH) || (cls == CL_BOTH) ||
                             ((cls == CL_ERASE || cls == CL_NOW_ERASE) &&
                              is_erase);
                end
            end
        endcase
    end

    // Command answer strobes
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cmd_accept <= 1'b0;
            o_cmd_ignore <= 1'b0;
            o_cmd_code   <= 8'h00;
        end else begin
            o_cmd_accept <= op_valid & accept;
            o_cmd_ignore <= op_valid & ~accept;
            if (op_valid) begin
                o_cmd_code <= op_shift;
            end
        end
    end

    // Operation state machine and latency counter
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state       <= ST_IDLE;
            kind        <= KIND_PAGE;
            op_addr     <= '0;
            nested_prog <= 1'b0;
            lat_cnt     <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (i_op_start) begin
                        state   <= ST_RUN;
                        kind    <= i_op_kind;
                        op_addr <= i_op_addr;
                    end
                end
                ST_RUN: begin
                    if (i_op_done) begin
                        state <= ST_IDLE;
                    end else if (op_valid && accept &&
                                 op_shift == OP_SUSPEND) begin
                        state   <= ST_SUSP_WAIT;
                        lat_cnt <= is_erase ? ERASE_LAT_CYC : PROG_LAT_CYC;
                    end
                end
                ST_SUSP_WAIT: begin
                    // RQ7 wait out the suspend latency
                    if (lat_cnt <= LAT_W'(1)) begin
                        state <= ST_SUSPENDED;
                    end else begin
                        lat_cnt <= lat_cnt - LAT_W'(1);
                    end
                end
                default: begin
                    if (nested_prog && i_op_done) begin
                        nested_prog <= 1'b0;
                    end else if (!nested_prog && i_op_start && is_erase &&
                                 i_op_kind == KIND_PAGE) begin
                        nested_prog <= 1'b1;
                    end
                    // RQ14 resume continues the operation
                    if (op_valid && accept && op_shift == OP_RESUME) begin
                        state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Status bits and engine pause
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_write_latch_bit       <= 1'b0;
            o_suspend_flag          <= 1'b0;
            o_write_in_progress_bit <= 1'b0;
            o_op_pause              <= 1'b0;
        end else begin
            o_op_pause <= (state == ST_SUSP_WAIT) ||
                          (state == ST_SUSPENDED && !nested_prog);
            o_write_in_progress_bit <= (state == ST_RUN) ||
                                       (state == ST_SUSP_WAIT) || nested_prog;
            // RQ8 flag follows suspend and resume
            if (state == ST_SUSP_WAIT && lat_cnt <= LAT_W'(1)) begin
                o_suspend_flag <= 1'b1;
            end else if (op_valid && accept && op_shift == OP_RESUME) begin
                o_suspend_flag <= 1'b0;
            end
            // RQ14 resume sets latch; latency end and completion clear it
            if (op_valid && accept &&
                (op_shift == OP_RESUME || op_shift == OP_LATCH_SET)) begin
                o_write_latch_bit <= 1'b1;
            end else if ((op_valid && accept && op_shift == OP_LATCH_CLEAR) ||
                         (state == ST_SUSP_WAIT && lat_cnt <= LAT_W'(1)) ||
                         i_op_done) begin
                o_write_latch_bit <= 1'b0;
            end
        end
    end

    // RQ6 read window excludes the suspended region
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_allowed <= 1'b1;
        end else begin
            o_rd_allowed <= !(o_suspend_flag &&
                ((i_rd_addr & region_mask(kind)) ==
                 (op_addr & region_mask(kind))));
        end
    end

    // Identity shifter; output changes on falling serial clock
    logic [ID_BITS-1:0]  id_shift;
    logic [ID_CNT_W-1:0] id_cnt;
    logic                id_active;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            id_shift  <= '0;
            id_cnt    <= '0;
            id_active <= 1'b0;
            o_so      <= 1'b0;
            o_so_oe_n <= 1'b1;
        end else if (!cs_low) begin
            // RQ2 RQ4 chip select high stops output, standby
            id_active <= 1'b0;
            o_so_oe_n <= 1'b1;
        end else if (op_valid && accept && op_shift == OP_IDENTITY_READ) begin
            // RQ1 maker byte then two device bytes
            id_shift  <= {MAKER_CODE, DEVICE_CODE};
            id_cnt    <= ID_CNT_W'(ID_BITS);
            id_active <= 1'b1;
        end else if (id_active && sclk_fall) begin
            if (id_cnt == '0) begin
                id_active <= 1'b0;
                o_so_oe_n <= 1'b1;
            end else begin
                o_so      <= id_shift[ID_BITS-1];
                o_so_oe_n <= 1'b0;
                id_shift  <= {id_shift[ID_BITS-2:0], 1'b0};
                id_cnt    <= id_cnt - ID_CNT_W'(1);
            end
        end
    end

    a_no_id_busy: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (op_valid && state == ST_RUN && op_shift == OP_IDENTITY_READ)
        |=> o_cmd_ignore && !id_active) // RQ3
        else $error("identity read decoded while busy");
    a_cs_stops_out: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !cs_low |=> o_so_oe_n && !id_active) // RQ4
        else $error("output still driven after chip select high");
    a_id_first_bit: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (id_active && sclk_fall && id_cnt == ID_CNT_W'(ID_BITS) && cs_low)
        |=> o_so == MAKER_CODE[7] && !o_so_oe_n) // RQ1
        else $error("identity readout does not start with maker msb");
    a_susp_flag_lat: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_suspend_flag) |-> $past(state) == ST_SUSP_WAIT &&
        !o_write_latch_bit) // RQ7
        else $error("suspend flag set without latency");
    a_resume_bits: assert property ( // RQ14
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (op_valid && accept && state == ST_SUSPENDED && op_shift == OP_RESUME)
        |=> o_write_latch_bit && !o_suspend_flag ##1 o_write_in_progress_bit)
        else $error("resume did not update status bits");
    a_never_in_susp: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (op_valid && state == ST_SUSPENDED && cls == CL_NEVER)
        |=> o_cmd_ignore && !o_cmd_accept) // RQ11
        else $error("refused opcode accepted in suspend");
    a_prog_susp_gate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (op_valid && state == ST_SUSPENDED && !is_erase && cls == CL_ERASE)
        |=> o_cmd_ignore && $stable(o_write_latch_bit)) // RQ10
        else $error("erase-only opcode accepted in program suspend");
    a_nested_resume: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (op_valid && nested_prog && op_shift == OP_RESUME)
        |=> o_cmd_ignore && state == ST_SUSPENDED) // RQ16
        else $error("resume accepted while nested program runs");
    a_read_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_suspend_flag && $stable(o_suspend_flag) &&
         (i_rd_addr & region_mask(kind)) == (op_addr & region_mask(kind)))
        |=> !o_rd_allowed) // RQ6
        else $error("read allowed inside suspended region");
endmodule
`default_nettype wire

//--- tb/fsid_host.sv
// Behavioural host controller that drives the serial link in SPI mode 0
`timescale 1ns/1ps
`default_nettype none
module fsid_host #(
    parameter int GAP_NS = 200
) (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    localparam realtime HALF = 40.0;

    // Clock stands low and chip select high outside frames
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
    end

    // Opcode goes out MSB first, data set while the clock is low
    task automatic send_byte(input logic [7:0] op);
        #3.7 o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            o_si = op[i];
            #HALF o_sclk = 1'b1;
            #HALF o_sclk = 1'b0;
        end
    endtask

    // Sample the output on each rising edge; own data line is don't care
    task automatic read_bits(input int n, output logic [23:0] bits);
        bits = '0;
        for (int i = 0; i < n; i++) begin
            o_si = ~o_si;
            #HALF o_sclk = 1'b1;
            bits = {bits[22:0], i_so};
            #HALF o_sclk = 1'b0;
        end
    endtask

    // frame may end at any bit
    task automatic end_frame();
        #20 o_cs_n = 1'b1;
        o_si = ~o_si;
    endtask

    task automatic resume_gap();
        #(GAP_NS);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the suspend gate and identity readout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fsid_pkg::*;
    localparam logic [7:0]  MAKER = 8'hC3;    // Arbitrary value
    localparam logic [15:0] DEV   = 16'h1E6B; // Arbitrary value
    logic        i_clk_sys, i_reset_n, i_op_start, i_op_done;
    logic        sclk, cs_n, si, so, so_oe_n, rd_ok, acc, ign, pause;
    logic        flag, latch, write_in_progress_bit;
    fsid_kind_e  i_op_kind;
    logic [23:0] i_op_addr, i_rd_addr;
    logic [7:0]  code;
    int          failures, n_checks;
    // Time at which the latest accept pulse was seen
    realtime     t_acc;

    fsid_top #(.PROG_LAT_NS(2000), .ERASE_LAT_NS(100), .MAKER_CODE(MAKER),
               .DEVICE_CODE(DEV)) u_fsid_top (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n),
        .i_op_start(i_op_start), .i_op_kind(i_op_kind),
        .i_op_addr(i_op_addr), .i_op_done(i_op_done),
        .i_rd_addr(i_rd_addr), .o_rd_allowed(rd_ok), .o_cmd_accept(acc),
        .o_cmd_ignore(ign), .o_cmd_code(code), .o_op_pause(pause),
        .o_suspend_flag(flag), .o_write_latch_bit(latch),
        .o_write_in_progress_bit(write_in_progress_bit));
    fsid_host u_fsid_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
                           .i_so(so));

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One opcode frame; waits for the accept or ignore pulse, bounded
    task automatic cmd(input logic [7:0] op, input logic ok, input bit keep);
        logic sa, si_;
        sa = 1'b0;
        si_ = 1'b0;
        fork
            u_fsid_host.send_byte(op);
            for (int k = 0; k < 300 && !(sa || si_); k++) begin
                @(posedge i_clk_sys);
                #1;
                sa = acc;
                si_ = ign;
                if (acc) begin
                    t_acc = $realtime;
                end
            end
        join
        if (!(sa || si_)) begin
            check(24'h1, 24'h0, "no response");
            test_done();
        end
        check({sa, si_}, ok ? 2'b10 : 2'b01, "accept or ignore");
        check(code, op, "opcode echo");
        if (!keep) u_fsid_host.end_frame();
        if (!keep) repeat (4) @(posedge i_clk_sys);
    endtask

    // Pulse the engine start (start=1) or done (start=0) input
    task automatic op_pulse(input logic start, input fsid_kind_e k,
                            input logic [23:0] a);
        @(posedge i_clk_sys);
        #1;
        i_op_start = start;
        i_op_done = !start;
        i_op_kind = k;
        i_op_addr = a;
        @(posedge i_clk_sys);
        #1;
        i_op_start = 1'b0;
        i_op_done = 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [23:0] a, input logic exp);
        @(posedge i_clk_sys);
        #1;
        i_rd_addr = a;
        repeat (2) @(posedge i_clk_sys);
        #1;
        check(rd_ok, exp, "read region");
    endtask

    // Count cycles until the suspend flag rises, bounded
    task automatic wait_flag(input int lim, output int n);
        n = 0;
        while (flag !== 1'b1) begin
            @(posedge i_clk_sys);
            #1;
            n++;
            if (n > lim) begin
                check(24'h1, 24'h0, "flag timeout");
                test_done();
            end
        end
    endtask

    task automatic s_identity();
        logic [23:0] got;
        cmd(OP_IDENTITY_READ, 1'b1, 1'b1);
        u_fsid_host.read_bits(24, got);
        check(got, {MAKER, DEV}, "identity bits");
        u_fsid_host.end_frame();
        repeat (5) @(posedge i_clk_sys);
        check(so_oe_n, 1'b1, "output released");
        cmd(OP_IDENTITY_READ, 1'b1, 1'b1);
        u_fsid_host.read_bits(6, got);
        check(got[5:0], MAKER[7:2], "early bits");
        u_fsid_host.end_frame();
        repeat (5) @(posedge i_clk_sys);
        check(so_oe_n, 1'b1, "abort releases");
        cmd(8'h05, 1'b1, 1'b0);
    endtask

    task automatic s_erase();
        int n;
        cmd(OP_LATCH_SET, 1'b1, 1'b0);
        check(latch, 1'b1, "latch set");
        op_pulse(1'b1, KIND_SECTOR, 24'h012345);
        cmd(OP_IDENTITY_READ, 1'b0, 1'b0);
        check({write_in_progress_bit, pause}, 2'b10, "op untouched");
        cmd(OP_SUSPEND, 1'b1, 1'b1);
        check(flag, 1'b0, "flag before latency");
        wait_flag(40, n);
        // Measured from the accept pulse, not from the end of the frame
        check(($realtime - t_acc) >= 95.0 && ($realtime - t_acc) <= 105.0,
              1'b1, "erase latency");
        u_fsid_host.end_frame();
        check({latch, pause, flag}, 3'b011, "suspended state");
        rd(24'h012000, 1'b0);
        rd(24'h012FFF, 1'b0);
        rd(24'h013000, 1'b1);
        rd(24'h011FFF, 1'b1);
        foreach (OPS_BOTH[i]) if (OPS_BOTH[i] != OP_RESUME) cmd(OPS_BOTH[i], 1'b1, 1'b0);
        foreach (OPS_ERASE[i]) cmd(OPS_ERASE[i], 1'b1, 1'b0);
        foreach (OPS_NEVER[i]) cmd(OPS_NEVER[i], 1'b0, 1'b0);
        cmd(8'h20, 1'b0, 1'b0);
        check(flag, 1'b1, "no side effect");
        op_pulse(1'b1, KIND_PAGE, 24'h200000);
        cmd(OP_RESUME, 1'b0, 1'b0);
        op_pulse(1'b0, KIND_PAGE, 24'h0);
        cmd(OP_RESUME, 1'b1, 1'b1);
        repeat (3) @(posedge i_clk_sys);
        check({flag, latch, write_in_progress_bit, pause}, 4'b0110, "resumed");
        u_fsid_host.end_frame();
        op_pulse(1'b0, KIND_PAGE, 24'h0);
    endtask

    task automatic s_program();
        int n;
        realtime t0;
        op_pulse(1'b1, KIND_PAGE, 24'h000140);
        u_fsid_host.resume_gap();
        cmd(OP_SUSPEND, 1'b1, 1'b0);
        t0 = t_acc;
        cmd(8'h05, 1'b1, 1'b0);
        cmd(8'h03, 1'b0, 1'b0);
        check(flag, 1'b0, "still in latency");
        wait_flag(500, n);
        check(($realtime - t0) >= 1995.0 && ($realtime - t0) <= 2005.0,
              1'b1, "program latency");
        rd(24'h000100, 1'b0);
        rd(24'h0001FF, 1'b0);
        rd(24'h000200, 1'b1);
        foreach (OPS_ERASE[i]) cmd(OPS_ERASE[i], 1'b0, 1'b0);
        foreach (OPS_NEVER[i]) cmd(OPS_NEVER[i], 1'b0, 1'b0);
        cmd(8'h03, 1'b1, 1'b0);
        cmd(OP_LATCH_CLEAR, 1'b1, 1'b0);
        check(latch, 1'b0, "latch cleared");
        cmd(8'h48, 1'b1, 1'b0);
        cmd(OP_RESUME, 1'b1, 1'b0);
        check(flag, 1'b0, "flag cleared");
        op_pulse(1'b0, KIND_PAGE, 24'h0);
    endtask

    initial begin
        failures = 0;
        n_checks = 0;
        i_reset_n = 1'b0;
        i_op_start = 1'b0;
        i_op_done = 1'b0;
        i_op_kind = KIND_PAGE;
        i_op_addr = '0;
        i_rd_addr = '0;
        repeat (6) @(posedge i_clk_sys);
        #1 i_reset_n = 1'b1;
        repeat (3) @(posedge i_clk_sys);
        s_identity();
        s_erase();
        s_program();
        test_done();
    end
endmodule
`default_nettype wire
